// File: rtl/ccu_pkg.sv
package ccu_pkg;
    // mode select field codes
    localparam logic [3:0] CCU_MODE_OFF    = 4'h0;
    localparam logic [3:0] CCU_MODE_TOGGLE = 4'h2;
    localparam logic [3:0] CCU_MODE_CAP_FE = 4'h4;
    localparam logic [3:0] CCU_MODE_CAP_RE = 4'h5;
    localparam logic [3:0] CCU_MODE_CAP_R4 = 4'h6;
    localparam logic [3:0] CCU_MODE_CAP_16 = 4'h7;
    localparam logic [3:0] CCU_MODE_SET_HI = 4'h8;
    localparam logic [3:0] CCU_MODE_SET_LO = 4'h9;
    localparam logic [3:0] CCU_MODE_SWINT  = 4'hA;
    localparam logic [3:0] CCU_MODE_SPEV   = 4'hB;
    // field positions in the unit control register
    localparam int CCU_MODE_LSB = 0;
    localparam int CCU_MODE_MSB = 3;
    // timer choice field codes
    localparam logic [1:0] CCU_TSEL_T1  = 2'h0;
    localparam logic [1:0] CCU_TSEL_T3A = 2'h1;
    localparam logic [1:0] CCU_TSEL_T3B = 2'h2;
    // prescaler terminal counts
    localparam logic [3:0] CCU_PS4_LAST  = 4'h3;
    localparam logic [3:0] CCU_PS16_LAST = 4'hF;
    // values after reset
    localparam logic [3:0]  CCU_MODE_RST  = 4'h0;
    localparam logic [3:0]  CCU_PS_RST    = 4'h0;
    localparam logic [15:0] CCU_VAL_RST   = 16'h0000;
    localparam logic        CCU_REMAP_RST = 1'b1;
    // units whose pins follow the remap bit
    localparam int CCU_REMAP_FIRST = 6;
    localparam int CCU_REMAP_LAST  = 9;
    // synchroniser depth
    localparam int CCU_SYNC_STAGES = 3;
endpackage

// File: rtl/ccu_sync_if.sv
interface ccu_sync_if;
    logic raw;
    logic level;
    modport src (output raw, input level);
    modport snk (input raw, output level);
endinterface

// File: rtl/ccu_pin_sync.sv
module ccu_pin_sync
    import ccu_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // pad level in, settled level out
    ccu_sync_if.snk  sif
);
    logic [CCU_SYNC_STAGES-1:0] stg_q;
    logic [CCU_SYNC_STAGES-1:0] stg_d;
    logic                       level_q;
    logic                       level_d;

    // shift chain; the level only moves when stages two and three agree
    always_comb begin
        stg_d   = {stg_q[CCU_SYNC_STAGES-2:0], sif.raw};
        level_d = level_q;
        if (stg_q[1] == stg_q[2]) begin
            level_d = stg_q[2];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            stg_q   <= '0;
            level_q <= 1'b0;
        end else begin
            stg_q   <= stg_d;
            level_q <= level_d;
        end
    end

    assign sif.level = level_q;
endmodule

// File: rtl/ccu_top.sv
// Contract
// - remap bit one primary, zero alternate pins
// - capture copies full 16-bit timer value
// - falling, rising, 4th or 16th rising
// - mode field bits 3:0 picks event
// - capture sets flag; only software clears
// - new capture overwrites unread old value
// - port write on output pin captures
// - prescaler cleared off, non-capture, reset
// - prescale switch keeps counter, may interrupt
// - compare register checked against selected timer
// - match drives high, low, toggles, or leaves
// - match sets flag with the pin action
// - clearing control forces compare latch low
// - mode 1010 only raises the interrupt
// - mode 1011 fires special event trigger
// - trigger resets the assigned timer pair
// - unit four trigger starts no conversion
// - timer choice 00 timer1, 01/10 timer3
// - value register is two byte registers
module ccu_top
    import ccu_pkg::*;
#(
    parameter int UNIT_NUM = 4
)
(
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    // configuration strap
    input  wire logic        pin_remap_select_in,
    // unit control register
    input  wire logic        ctrl_wr_in,
    input  wire logic [7:0]  ctrl_wdata_in,
    output logic      [7:0]  ctrl_out,
    // value register bytes
    input  wire logic        val_lo_wr_in,
    input  wire logic        val_hi_wr_in,
    input  wire logic [7:0]  val_wdata_in,
    output logic      [7:0]  capture_value_low_out,
    output logic      [7:0]  capture_value_high_out,
    // timer choice, timers and triggers
    input  wire logic [1:0]  timer_choice_field_in,
    input  wire logic [15:0] timer1_value_in,
    input  wire logic [15:0] timer3_value_in,
    output logic             timer1_reset_out,
    output logic             timer3_reset_out,
    output logic             adc_start_out,
    output logic             special_event_out,
    // flag and enable
    input  wire logic        unit_event_enable_in,
    input  wire logic        flag_clear_in,
    output logic             unit_event_flag_out,
    output logic             irq_out,
    // port side of the pin
    input  wire logic        pin_direction_bit_in,
    input  wire logic        port_latch_in,
    // primary pin set
    input  wire logic        pin_pri_in,
    output logic             pin_pri_out,
    output logic             pin_pri_oe_out,
    // alternate pin set
    input  wire logic        pin_alt_in,
    output logic             pin_alt_out,
    output logic             pin_alt_oe_out
);
    localparam bit REMAP_UNIT = (UNIT_NUM >= CCU_REMAP_FIRST) && (UNIT_NUM <= CCU_REMAP_LAST);

    ccu_sync_if sif ();

    logic        remap_q, remap_d, strap_done_q, strap_done_d;
    logic        use_alt;
    logic        cap_src, src_q, src_d, rise, fall;
    logic [3:0]  mode_q, mode_d;
    logic        is_cap, is_cmp;
    logic [3:0]  ps_q, ps_d;
    logic        cap_evt;
    logic [15:0] val_q, val_d, tmr_val;
    logic        tmr_ok, match, match_q, match_d, cmp_evt;
    logic        cmp_latch_q, cmp_latch_d;
    logic        flag_q, flag_d, irq_q, irq_d;
    logic        trig_q, trig_d, t1r_q, t1r_d, t3r_q, t3r_d;
    logic        drv_q, drv_d, oe_q, oe_d, oe_alt_q, oe_alt_d;

    // remap strap caught once, on the first edge after reset release
    always_comb begin
        remap_d      = remap_q;
        strap_done_d = 1'b1;
        if (!strap_done_q) begin
            remap_d = pin_remap_select_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            remap_q      <= CCU_REMAP_RST;
            strap_done_q <= 1'b0;
        end else begin
            remap_q      <= remap_d;
            strap_done_q <= strap_done_d;
        end
    end

    // pad selection by the remap bit
    assign use_alt = REMAP_UNIT && !remap_q;
    assign sif.raw = use_alt ? pin_alt_in : pin_pri_in;

    ccu_pin_sync u_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .sif         (sif)
    );

    // an output pin shows the port latch, so a port write is an edge too
    always_comb begin
        cap_src = pin_direction_bit_in ? sif.level : port_latch_in;
        src_d   = cap_src;
        rise    = cap_src && !src_q;
        fall    = !cap_src && src_q;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            src_q <= 1'b0;
        end else begin
            src_q <= src_d;
        end
    end

    // unit control register: only the mode field is implemented
    always_comb begin
        mode_d = mode_q;
        if (ctrl_wr_in) begin
            mode_d = ctrl_wdata_in[CCU_MODE_MSB:CCU_MODE_LSB];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            mode_q <= CCU_MODE_RST;
        end else begin
            mode_q <= mode_d;
        end
    end

    assign is_cap = (mode_q >= CCU_MODE_CAP_FE) && (mode_q <= CCU_MODE_CAP_16);
    assign is_cmp = (mode_q == CCU_MODE_TOGGLE) || (mode_q >= CCU_MODE_SET_HI);

    // prescaler; a direct switch between capture modes keeps the count
    always_comb begin
        ps_d    = ps_q;
        cap_evt = 1'b0;
        if (!is_cap) begin
            ps_d = CCU_PS_RST;
        end else begin
            case (mode_q)
                CCU_MODE_CAP_FE: cap_evt = fall;
                CCU_MODE_CAP_RE: cap_evt = rise;
                CCU_MODE_CAP_R4: begin
                    if (rise) begin
                        cap_evt = (ps_q >= CCU_PS4_LAST);
                        ps_d    = cap_evt ? CCU_PS_RST : ps_q + 4'h1;
                    end
                end
                CCU_MODE_CAP_16: begin
                    if (rise) begin
                        cap_evt = (ps_q == CCU_PS16_LAST);
                        ps_d    = ps_q + 4'h1;
                    end
                end
                default: cap_evt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ps_q <= CCU_PS_RST;
        end else begin
            ps_q <= ps_d;
        end
    end

    // timer choice; the reserved code selects no timer
    always_comb begin
        tmr_ok = 1'b1;
        case (timer_choice_field_in)
            CCU_TSEL_T1:  tmr_val = timer1_value_in;
            CCU_TSEL_T3A: tmr_val = timer3_value_in;
            CCU_TSEL_T3B: tmr_val = timer3_value_in;
            default: begin
                tmr_val = CCU_VAL_RST;
                tmr_ok  = 1'b0;
            end
        endcase
    end

    // value register: a capture beats a software byte write
    always_comb begin
        val_d = val_q;
        if (val_lo_wr_in) begin
            val_d[7:0] = val_wdata_in;
        end
        if (val_hi_wr_in) begin
            val_d[15:8] = val_wdata_in;
        end
        if (cap_evt) begin
            val_d = tmr_val;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            val_q <= CCU_VAL_RST;
        end else begin
            val_q <= val_d;
        end
    end

    // compare: only the first cycle of a match is an event
    always_comb begin
        match   = is_cmp && tmr_ok && (tmr_val == val_q);
        match_d = match;
        cmp_evt = match && !match_q;
    end

    // compare output latch, separate from the port latch
    always_comb begin
        cmp_latch_d = cmp_latch_q;
        if (ctrl_wr_in && ctrl_wdata_in == 8'h00) begin
            cmp_latch_d = 1'b0;
        end else if (ctrl_wr_in) begin
            case (ctrl_wdata_in[CCU_MODE_MSB:CCU_MODE_LSB])
                CCU_MODE_SET_HI: cmp_latch_d = 1'b0;
                CCU_MODE_SET_LO: cmp_latch_d = 1'b1;
                default:         cmp_latch_d = cmp_latch_q;
            endcase
        end else if (cmp_evt) begin
            case (mode_q)
                CCU_MODE_SET_HI: cmp_latch_d = 1'b1;
                CCU_MODE_SET_LO: cmp_latch_d = 1'b0;
                CCU_MODE_TOGGLE: cmp_latch_d = !cmp_latch_q;
                default:         cmp_latch_d = cmp_latch_q;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            match_q     <= 1'b0;
            cmp_latch_q <= 1'b0;
        end else begin
            match_q     <= match_d;
            cmp_latch_q <= cmp_latch_d;
        end
    end

    // flag: hardware sets, software clears; a set in the clear cycle wins
    always_comb begin
        flag_d = flag_q;
        if (flag_clear_in) begin
            flag_d = 1'b0;
        end
        if (cap_evt || cmp_evt) begin
            flag_d = 1'b1;
        end
        irq_d = flag_d && unit_event_enable_in;
    end

    // special event trigger; this unit never starts a conversion
    always_comb begin
        trig_d = cmp_evt && (mode_q == CCU_MODE_SPEV);
        t1r_d  = trig_d && (timer_choice_field_in == CCU_TSEL_T1);
        t3r_d  = trig_d && ((timer_choice_field_in == CCU_TSEL_T3A)
                         || (timer_choice_field_in == CCU_TSEL_T3B));
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            flag_q <= 1'b0;
            irq_q  <= 1'b0;
            trig_q <= 1'b0;
            t1r_q  <= 1'b0;
            t3r_q  <= 1'b0;
        end else begin
            flag_q <= flag_d;
            irq_q  <= irq_d;
            trig_q <= trig_d;
            t1r_q  <= t1r_d;
            t3r_q  <= t3r_d;
        end
    end

    // pin drive: latch in pin-action compare modes, else the port latch
    always_comb begin
        oe_d     = !pin_direction_bit_in && !use_alt;
        oe_alt_d = !pin_direction_bit_in && use_alt;
        drv_d = port_latch_in;
        if (mode_q == CCU_MODE_SET_HI || mode_q == CCU_MODE_SET_LO
            || mode_q == CCU_MODE_TOGGLE) begin
            drv_d = cmp_latch_d;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            drv_q    <= 1'b0;
            oe_q     <= 1'b0;
            oe_alt_q <= 1'b0;
        end else begin
            drv_q    <= drv_d;
            oe_q     <= oe_d;
            oe_alt_q <= oe_alt_d;
        end
    end

    // outputs, all from flops except adc_start_out, tied low; the unused pin set is undriven except in the first cycle after reset on an alternate-pin unit
    assign ctrl_out               = {4'h0, mode_q};
    assign capture_value_low_out  = val_q[7:0];
    assign capture_value_high_out = val_q[15:8];
    assign unit_event_flag_out    = flag_q;
    assign irq_out                = irq_q;
    assign special_event_out      = trig_q;
    assign timer1_reset_out       = t1r_q;
    assign timer3_reset_out       = t3r_q;
    assign adc_start_out          = 1'b0;
    assign pin_pri_out            = drv_q;
    assign pin_alt_out            = drv_q;
    assign pin_pri_oe_out         = oe_q;
    assign pin_alt_oe_out         = oe_alt_q;
endmodule

// File: tb/ccu_top_asserts.sv
module ccu_top_asserts #(
    parameter int UNIT_NUM = 4
)
(
    // clock and reset
    input wire logic       core_clk_in,
    input wire logic       rst_n_in,
    // register side
    input wire logic       ctrl_wr_in,
    input wire logic [7:0] ctrl_wdata_in,
    input wire logic [7:0] ctrl_out,
    input wire logic       val_lo_wr_in,
    input wire logic [7:0] val_wdata_in,
    input wire logic [7:0] capture_value_low_out,
    // triggers
    input wire logic       timer1_reset_out,
    input wire logic       timer3_reset_out,
    input wire logic       adc_start_out,
    input wire logic       special_event_out,
    // flag side and alternate pin enable
    input wire logic       unit_event_enable_in,
    input wire logic       flag_clear_in,
    input wire logic       unit_event_flag_out,
    input wire logic       irq_out,
    input wire logic       pin_alt_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // one domain, so one clock and one disable for all
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_adc_never_started: assert property (!adc_start_out)
        else $error("adc start pulsed");
    a_trigger_one_cycle: assert property (special_event_out |=> !special_event_out)
        else $error("trigger longer than a cycle");
    a_trigger_resets_timer: assert property (
        special_event_out |-> (timer1_reset_out || timer3_reset_out))
        else $error("trigger without timer reset");
    a_timer_reset_cause: assert property (
        (timer1_reset_out || timer3_reset_out) |-> special_event_out)
        else $error("timer reset without trigger");
    a_flag_sticky: assert property ($fell(unit_event_flag_out) |-> $past(flag_clear_in))
        else $error("flag dropped without clear");
    a_irq_gated: assert property (
        irq_out == (unit_event_flag_out && $past(unit_event_enable_in)))
        else $error("irq not flag and enable");
    a_ctrl_mode_write: assert property (
        ctrl_wr_in |=> ctrl_out == {4'h0, $past(ctrl_wdata_in[3:0])})
        else $error("mode field not stored");
    a_ctrl_upper_zero: assert property (ctrl_out[7:4] == 4'h0)
        else $error("control upper bits set");
    a_low_byte_write: assert property (
        val_lo_wr_in && ctrl_out[3:2] != 2'b01 |=> capture_value_low_out == $past(val_wdata_in))
        else $error("low byte not stored");
    a_alt_pins_idle: assert property (
        (UNIT_NUM < 6 || UNIT_NUM > 9) |-> !pin_alt_oe_out)
        else $error("alternate pin driven");
endmodule

bind ccu_top ccu_top_asserts #(.UNIT_NUM(UNIT_NUM)) u_chk (.core_clk_in, .rst_n_in,
    .ctrl_wr_in, .ctrl_wdata_in, .ctrl_out, .val_lo_wr_in, .val_wdata_in,
    .capture_value_low_out, .timer1_reset_out, .timer3_reset_out, .adc_start_out,
    .special_event_out, .unit_event_enable_in, .flag_clear_in, .unit_event_flag_out,
    .irq_out, .pin_alt_oe_out);

// File: tb/ccu_pad_model.sv
module ccu_pad_model (
    // clock
    input wire logic core_clk_in,
    // outside source and device drive
    input wire logic ext_level_in,
    input wire logic pin_out_in,
    input wire logic pin_oe_in,
    // pad levels seen by the device
    output logic     pad_out,
    output logic     alt_pad_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // a driving device wins over the outside source
    assign pad_out = pin_oe_in ? pin_out_in : ext_level_in;
    // unused pad set wanders, so a stale level never looks valid
    always @(posedge core_clk_in) alt_pad_out <= (alt_pad_out !== 1'b1);
endmodule

// File: tb/test_capture_compare_unit.sv
module test_capture_compare_unit;
    timeunit 1ns;
    timeprecision 1ps;
    import ccu_pkg::*;
    logic        clk, rst_n, ctrl_wr, lo_wr, hi_wr, clr, en, dir, plat, ext, run, tload;
    logic [7:0]  wdata, ctrl, vlo, vhi;
    logic [1:0]  tsel;
    logic [15:0] t1, t3, tset;
    logic        t1r, t3r, adc, spev, flag, irq, pad, alt, po, poe, ao, aoe, p6oe, a6oe;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    ccu_top uut (.core_clk_in(clk), .rst_n_in(rst_n), .pin_remap_select_in(1'b0),
        .ctrl_wr_in(ctrl_wr), .ctrl_wdata_in(wdata), .ctrl_out(ctrl),
        .val_lo_wr_in(lo_wr), .val_hi_wr_in(hi_wr), .val_wdata_in(wdata),
        .capture_value_low_out(vlo), .capture_value_high_out(vhi),
        .timer_choice_field_in(tsel), .timer1_value_in(t1), .timer3_value_in(t3),
        .timer1_reset_out(t1r), .timer3_reset_out(t3r), .adc_start_out(adc),
        .special_event_out(spev), .unit_event_enable_in(en), .flag_clear_in(clr),
        .unit_event_flag_out(flag), .irq_out(irq), .pin_direction_bit_in(dir),
        .port_latch_in(plat), .pin_pri_in(pad), .pin_pri_out(po), .pin_pri_oe_out(poe),
        .pin_alt_in(alt), .pin_alt_out(ao), .pin_alt_oe_out(aoe));
    // a remappable unit with the strap at zero, only its enables are watched
    ccu_top #(.UNIT_NUM(6)) uut6 (.core_clk_in(clk), .rst_n_in(rst_n),
        .pin_remap_select_in(1'b0), .ctrl_wr_in(ctrl_wr), .ctrl_wdata_in(wdata),
        .ctrl_out(), .val_lo_wr_in(lo_wr), .val_hi_wr_in(hi_wr),
        .val_wdata_in(wdata), .capture_value_low_out(), .capture_value_high_out(),
        .timer_choice_field_in(tsel), .timer1_value_in(t1), .timer3_value_in(t3),
        .timer1_reset_out(), .timer3_reset_out(), .adc_start_out(),
        .special_event_out(), .unit_event_enable_in(en), .flag_clear_in(clr),
        .unit_event_flag_out(), .irq_out(), .pin_direction_bit_in(dir),
        .port_latch_in(plat), .pin_pri_in(ext), .pin_pri_out(),
        .pin_pri_oe_out(p6oe), .pin_alt_in(alt), .pin_alt_out(),
        .pin_alt_oe_out(a6oe));
    ccu_pad_model pad_m (.core_clk_in(clk), .ext_level_in(ext), .pin_out_in(po),
        .pin_oe_in(poe), .pad_out(pad), .alt_pad_out(alt));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // timer in the same clock domain, cleared by the trigger
    always @(posedge clk) begin
        if (!rst_n) t1 <= 16'h0000;
        else if (tload) t1 <= tset;
        else if (t1r) t1 <= 16'h0000;
        else if (run) t1 <= t1 + 16'h0001;
    end
    // hang guard, far above the several hundred cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // sel 0 control, 1 low byte, 2 high byte
    task automatic wr(input int sel, input logic [7:0] v);
        @(posedge clk);
        wdata <= v;
        ctrl_wr <= (sel == 0);
        lo_wr <= (sel == 1);
        hi_wr <= (sel == 2);
        @(posedge clk);
        {ctrl_wr, lo_wr, hi_wr} <= 3'h0;
        #1;
    endtask
    // level held long enough to clear the sync chain
    task automatic pulse(input logic lvl);
        @(posedge clk) ext <= lvl;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic clear();
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic load(input logic [15:0] v);
        @(posedge clk) tset <= v;
        tload <= 1'b1;
        @(posedge clk) tload <= 1'b0;
    endtask
    task automatic wait_flag();
        for (int i = 0; i < 200 && flag !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask

    initial begin
        logic [3:0] m;
        {rst_n, ctrl_wr, lo_wr, hi_wr, clr, en, dir, plat, ext, run, tload} = '0;
        {wdata, tsel, t3, tset} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check(ctrl, 16'h0000);
        check({vhi, vlo}, 16'h0000);
        check(flag, 16'h0000);
        $display("test reset done");
        wr(1, 8'hAB);
        wr(2, 8'hCD);
        check({vhi, vlo}, 16'hCDAB);
        $display("test bytes done");
        // capture on rising edges, newer value overwrites
        @(posedge clk) dir <= 1'b1;
        en <= 1'b1;
        load(16'h1234);
        wr(0, CCU_MODE_CAP_RE);
        clear();
        pulse(1'b1);
        check({vhi, vlo}, 16'h1234);
        check(flag, 16'h0001);
        check(irq, 16'h0001);
        load(16'h5678);
        pulse(1'b0);
        pulse(1'b1);
        check({vhi, vlo}, 16'h5678);
        clear();
        check(flag, 16'h0000);
        $display("test capture rise done");
        // falling edges from timer three
        @(posedge clk) tsel <= CCU_TSEL_T3A;
        t3 <= 16'h9ABC;
        wr(0, CCU_MODE_CAP_FE);
        clear();
        pulse(1'b0);
        check({vhi, vlo}, 16'h9ABC);
        clear();
        pulse(1'b1);
        check(flag, 16'h0000);
        $display("test capture fall done");
        // prescaled captures, unit turned off between settings
        for (int k = 0; k < 2; k++) begin
            wr(0, CCU_MODE_OFF);
            wr(0, k ? CCU_MODE_CAP_16 : CCU_MODE_CAP_R4);
            clear();
            repeat ((k ? 16 : 4) - 1) begin
                pulse(1'b0);
                pulse(1'b1);
            end
            check(flag, 16'h0000);
            pulse(1'b0);
            pulse(1'b1);
            check(flag, 16'h0001);
        end
        $display("test prescale done");
        // port write on an output pin acts as an edge
        @(posedge clk) dir <= 1'b0;
        tsel <= CCU_TSEL_T1;
        wr(0, CCU_MODE_CAP_RE);
        load(16'h0BEE);
        clear();
        @(posedge clk) plat <= 1'b1;
        wait_flag();
        check({vhi, vlo}, 16'h0BEE);
        $display("test port capture done");
        // special event trigger period
        @(posedge clk) plat <= 1'b0;
        wr(1, 8'h20);
        wr(2, 8'h00);
        load(16'h0000);
        wr(0, CCU_MODE_SPEV);
        clear();
        @(posedge clk) run <= 1'b1;
        for (int i = 0; i < 100 && spev !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check(t1r, 16'h0001);
        check(t3r, 16'h0000);
        check(flag, 16'h0001);
        check(adc, 16'h0000);
        @(posedge clk);
        #1;
        check(spev, 16'h0000);
        check(t1, 16'h0000);
        $display("test special event done");
        // pin actions: high and toggle from the cleared latch, low from the latch set by its mode write
        for (int k = 0; k < 3; k++) begin
            m = (k == 0) ? CCU_MODE_SET_HI : (k == 1) ? CCU_MODE_SET_LO : CCU_MODE_TOGGLE;
            @(posedge clk) run <= 1'b0;
            wr(0, CCU_MODE_OFF);
            check(po, 16'h0000);
            wr(0, m);
            load(16'h0000);
            clear();
            @(posedge clk) run <= 1'b1;
            wait_flag();
            @(posedge clk);
            #1;
            check(po, (k == 1) ? 16'h0000 : 16'h0001);
            check(poe, 16'h0001);
        end
        // latch is high after the toggle; clearing control must drop it
        wr(0, CCU_MODE_OFF);
        wr(0, CCU_MODE_TOGGLE);
        @(posedge clk);
        #1;
        check(po, 16'h0000);
        $display("test pin action done");
        // software interrupt leaves the pin on the port latch
        @(posedge clk) run <= 1'b0;
        plat <= 1'b1;
        wr(0, CCU_MODE_SWINT);
        load(16'h0000);
        clear();
        @(posedge clk) run <= 1'b1;
        wait_flag();
        check(irq, 16'h0001);
        check(po, 16'h0001);
        $display("test soft interrupt done");
        check(aoe, 16'h0000);
        check(p6oe, 16'h0000);
        check(a6oe, 16'h0001);
        $display("test remap done");
        close_out();
    end
endmodule
